// *** usb_device_status_control.sv ***
// Purpose: error enables, transaction status fifo and module control for a usb device
// Assumes: apb slave with zero wait states, engine events are one-cycle pulses
// Notes: read data is captured in the setup cycle, writes land at the access edge
`timescale 1ns/100ps
`default_nettype none

module usb_device_status_control
   import usb_status_pkg::*;
#(
   parameter int EP_COUNT = NUM_EP,
   parameter int DB_FIRST = FIRST_DB_EP,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,                      // system clock, 250 MHz
   input wire logic resetn,                   // async reset, active low
   input wire logic psel,                     // apb select
   input wire logic penable,                  // apb access phase
   input wire logic pwrite,                   // apb direction, 1 is write
   input wire logic [11:0] paddr,             // apb byte address
   input wire logic [31:0] pwdata,            // apb write data
   output logic pready,                       // apb ready
   output logic [31:0] prdata,                // apb read data
   output logic pslverr,                      // apb error, unmapped address
   input wire logic [7:0] err_event,          // error detections from the engine
   input wire logic txn_done,                 // descriptor consumed, pulse
   input wire logic [3:0] txn_endpoint,       // endpoint of the finished transaction
   input wire logic txn_dir_in,               // 1 for in, 0 for out
   input wire logic txn_odd,                  // 1 when odd bank updated
   output logic txn_ready,                    // status fifo has room
   input wire logic setup_token,              // setup token seen, pulse
   output logic error_summary,                // error bit to main interrupt status
   output logic token_done_flag,              // token done interrupt flag
   output logic txn_halt,                     // stop packet tx and rx
   output logic resume_drive,                 // drive resume signaling on the bus
   output logic [EP_COUNT-1:0] pingpong_clear, // force odd selector to even, per endpoint
   output logic engine_reset,                 // serial engine state reset, pulse
   output logic module_enable                 // module operating
);

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic setup_ph;
   logic wr_acc;
   logic hit;
   logic wr_err_en;
   logic wr_ctl;
   logic wr_flags;
   logic wr_irq;
   logic [7:0] wbyte;

   // no wait states: every access phase completes at once
   assign pready = 1'b1;
   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign wbyte = pwdata[7:0];
   assign hit = (paddr == ERR_EN_OFS) || (paddr == STATUS_OFS) || (paddr == CTL_OFS) ||
                (paddr == ERR_FLAG_OFS) || (paddr == IRQ_OFS);
   assign pslverr = psel && penable && !hit;
   assign wr_err_en = wr_acc && (paddr == ERR_EN_OFS);
   assign wr_ctl = wr_acc && (paddr == CTL_OFS);
   assign wr_flags = wr_acc && (paddr == ERR_FLAG_OFS);
   assign wr_irq = wr_acc && (paddr == IRQ_OFS);

   ////////////////////////////////////////////////////////////////////////////
   // error enables and sticky error flags

   logic [7:0] err_en_q;
   logic [7:0] err_flag_q;
   logic [7:0] err_flag_d;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         err_en_q <= REG_RESET;
      end else if (wr_err_en) begin
         err_en_q <= wbyte & ERR_MASK;
      end
   end

   always_comb begin
      err_flag_d = err_flag_q;
      if (wr_flags) begin
         err_flag_d = err_flag_d & ~wbyte;
      end
      err_flag_d = (err_flag_d | err_event) & ERR_MASK;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         err_flag_q <= REG_RESET;
      end else begin
         err_flag_q <= err_flag_d;
      end
   end

   assign error_summary = |(err_flag_q & err_en_q);

   ////////////////////////////////////////////////////////////////////////////
   // transaction status fifo

   logic [STAT_W-1:0] stat_entry;
   logic [STAT_W-1:0] head_data;
   logic head_valid;
   logic tok_pop;

   always_comb begin
      stat_entry = '0;
      stat_entry[STAT_EP_MSB:STAT_EP_LSB] = txn_endpoint;
      stat_entry[STAT_DIR] = txn_dir_in;
      stat_entry[STAT_ODD] = txn_odd;
   end

   assign tok_pop = wr_irq && wbyte[IRQ_TOKDONE];

   // one entry per descriptor
   // the engine must wait on txn_ready; a full queue never drops an entry
   status_fifo #(
      .WIDTH(STAT_W),
      .DEPTH(DEPTH)
   ) u_status_fifo (
      .clk(clk),
      .resetn(resetn),
      .push_valid(txn_done),
      .push_ready(txn_ready),
      .push_data(stat_entry),
      .pop(tok_pop),
      .head_valid(head_valid),
      .head_data(head_data)
   );

   assign token_done_flag = head_valid;

   ////////////////////////////////////////////////////////////////////////////
   // control register

   logic suspend_q;
   logic resume_q;
   logic pprst_q;
   logic enable_q;
   logic engine_reset_q;

   // software clear resumes
   // a setup token in the same cycle as the clear keeps the bit set
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         suspend_q <= 1'b0;
      end else if (setup_token) begin
         suspend_q <= 1'b1;
      end else if (wr_ctl && !wbyte[CTL_SUSPEND]) begin
         suspend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resume_q <= 1'b0;
         pprst_q <= 1'b0;
         enable_q <= 1'b0;
      end else if (wr_ctl) begin
         resume_q <= wbyte[CTL_RESUME];
         pprst_q <= wbyte[CTL_PPRST];
         enable_q <= wbyte[CTL_ENABLE];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         engine_reset_q <= 1'b0;
      end else begin
         engine_reset_q <= wr_ctl && wbyte[CTL_ENABLE] && !enable_q;
      end
   end

   assign txn_halt = suspend_q;
   // software owns duration
   // the bit is passed straight through; no timer here, software holds it long enough
   assign resume_drive = resume_q;
   // transceiver untouched
   // no transceiver or regulator control exists on this block, so enable cannot reach them
   assign module_enable = enable_q;
   assign engine_reset = engine_reset_q;

   // per endpoint clear
   // only double-buffered endpoints own an odd selector worth clearing
   for (genvar ep = 0; ep < EP_COUNT; ep++) begin : g_pp
      if (ep >= DB_FIRST) begin : g_db
         assign pingpong_clear[ep] = pprst_q || engine_reset_q;
      end else begin : g_sb
         assign pingpong_clear[ep] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   logic [7:0] rd_byte;
   logic [7:0] ctl_view;
   logic [7:0] irq_view;
   logic [31:0] prdata_q;

   always_comb begin
      ctl_view = '0;
      ctl_view[CTL_SUSPEND] = suspend_q;
      ctl_view[CTL_RESUME] = resume_q;
      ctl_view[CTL_PPRST] = pprst_q;
      ctl_view[CTL_ENABLE] = enable_q;
      irq_view = '0;
      irq_view[IRQ_TOKDONE] = head_valid;
      irq_view[IRQ_ERROR] = error_summary;
   end

   always_comb begin
      case (paddr)
         ERR_EN_OFS: rd_byte = err_en_q;
         STATUS_OFS: rd_byte = head_valid ? head_data : 8'h00;
         CTL_OFS: rd_byte = ctl_view;
         ERR_FLAG_OFS: rd_byte = err_flag_q;
         IRQ_OFS: rd_byte = irq_view;
         default: rd_byte = 8'h00;
      endcase
   end

   // captured in setup so prdata comes from a flop during the access phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_q <= '0;
      end else if (setup_ph) begin
         prdata_q <= {24'h000000, rd_byte};
      end
   end

   assign prdata = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_ctl_enable_rise;
      wr_ctl && wbyte[CTL_ENABLE] && !enable_q;
   endsequence

   sequence s_one_pulse;
      engine_reset ##1 !engine_reset;
   endsequence

   sequence s_tok_clear_more;
      tok_pop && head_valid && !txn_ready ##0 1'b1;
   endsequence

   property p_err_en_gate;
      @(posedge clk) disable iff (!resetn)
      (err_event[ERR_BITSTUFF] && err_en_q[ERR_BITSTUFF] && !wr_err_en) |=> error_summary;
   endproperty
   a_err_en_gate: assert property (p_err_en_gate) else $error("enabled stuff error missed summary");

   property p_err_mask;
      @(posedge clk) disable iff (!resetn)
      (err_en_q == 8'h00) |-> !error_summary;
   endproperty
   a_err_mask: assert property (p_err_mask) else $error("summary raised with all enables off");

   property p_summary_or;
      @(posedge clk) disable iff (!resetn)
      error_summary == ((err_flag_q[ERR_PID] && err_en_q[ERR_PID]) || |(err_flag_q[7:1] & err_en_q[7:1]));
   endproperty
   a_summary_or: assert property (p_summary_or) else $error("summary differs from masked flags");

   property p_flag_sticky;
      @(posedge clk) disable iff (!resetn)
      (err_flag_q[ERR_CRC16] && !(wr_flags && wbyte[ERR_CRC16])) |=> err_flag_q[ERR_CRC16];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("error flag dropped without clear");

   property p_flag_w1c;
      @(posedge clk) disable iff (!resetn)
      (wr_flags && wbyte[ERR_CRC5] && !err_event[ERR_CRC5]) |=> !err_flag_q[ERR_CRC5];
   endproperty
   a_flag_w1c: assert property (p_flag_w1c) else $error("write one did not clear flag");

   property p_push_shows;
      @(posedge clk) disable iff (!resetn)
      (txn_done && txn_ready) |=> token_done_flag;
   endproperty
   a_push_shows: assert property (p_push_shows) else $error("completed transaction not flagged");

   property p_first_entry;
      @(posedge clk) disable iff (!resetn)
      (txn_done && !head_valid) |=> (head_data == $past(stat_entry));
   endproperty
   a_first_entry: assert property (p_first_entry) else $error("head differs from pushed status");

   property p_reassert;
      @(posedge clk) disable iff (!resetn)
      s_tok_clear_more |=> token_done_flag;
   endproperty
   a_reassert: assert property (p_reassert) else $error("token done not reasserted with queued entry");

   property p_setup_halts;
      @(posedge clk) disable iff (!resetn)
      setup_token |=> (txn_halt && ctl_view[CTL_SUSPEND]);
   endproperty
   a_setup_halts: assert property (p_setup_halts) else $error("setup token did not suspend");

   property p_suspend_clear;
      @(posedge clk) disable iff (!resetn)
      (wr_ctl && !wbyte[CTL_SUSPEND] && !setup_token) |=> !txn_halt;
   endproperty
   a_suspend_clear: assert property (p_suspend_clear) else $error("suspend not cleared by software");

   property p_resume_follow;
      @(posedge clk) disable iff (!resetn)
      wr_ctl |=> (resume_drive == $past(wbyte[CTL_RESUME]));
   endproperty
   a_resume_follow: assert property (p_resume_follow) else $error("resume drive not following control");

   property p_pp_single;
      @(posedge clk) disable iff (!resetn)
      pingpong_clear[DB_FIRST-1:0] == '0;
   endproperty
   a_pp_single: assert property (p_pp_single) else $error("single-buffered endpoint selector touched");

   property p_pp_db;
      @(posedge clk) disable iff (!resetn)
      (wr_ctl && wbyte[CTL_PPRST]) |=> pingpong_clear[EP_COUNT-1];
   endproperty
   a_pp_db: assert property (p_pp_db) else $error("ping-pong reset did not reach endpoint");

   property p_enable_pulse;
      @(posedge clk) disable iff (!resetn)
      s_ctl_enable_rise |=> s_one_pulse;
   endproperty
   a_enable_pulse: assert property (p_enable_pulse) else $error("enable rise gave no single reset pulse");

   property p_enable_level;
      @(posedge clk) disable iff (!resetn)
      wr_ctl |=> (module_enable == $past(wbyte[CTL_ENABLE]));
   endproperty
   a_enable_level: assert property (p_enable_level) else $error("module enable not following control");

endmodule
`default_nettype wire

// *** usb_status_pkg.sv ***
// Purpose: shared constants for the usb device status and control slice
// Assumes: apb register window, 32-bit data, 8-bit registers in the low bits
// Notes: offsets are byte addresses, one aligned word per register
//
// Notes on behaviour
// - enable bits 7,5,4 gate stuff/buffer/turnaround errors
// - enable bits 3..0 gate length/crc16/crc5/pid errors
// - enabled error flags or into summary bit
// - error flag stays until software writes one
// - each completed transaction produces one status entry
// - status entries queue in four-byte fifo
// - clearing token done advances to next entry
// - token done reasserts at once if entry valid
// - status bits 7..4 hold endpoint number
// - status bit 3 gives direction, 1 is in
// - status bit 2 gives bank, 1 is odd
// - setup token sets suspend, halts packet traffic
// - software clears suspend, token processing resumes
// - control bit 2 drives resume signaling
// - control bit 1 forces ping-pong selectors even
// - ping-pong reset touches only endpoints 5 and 6
// - control bit 0 enables the module
// - enabling clears odd selectors, resets engine state
// - enable leaves transceiver and regulator alone

package usb_status_pkg;

   // register byte offsets
   localparam logic [11:0] ERR_EN_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] CTL_OFS = 12'h008;
   localparam logic [11:0] ERR_FLAG_OFS = 12'h00c;
   localparam logic [11:0] IRQ_OFS = 12'h010;

   // error enable and error flag field positions
   localparam int ERR_BITSTUFF = 7;
   localparam int ERR_BUFFER = 5;
   localparam int ERR_TURNAROUND = 4;
   localparam int ERR_DATA_LEN = 3;
   localparam int ERR_CRC16 = 2;
   localparam int ERR_CRC5 = 1;
   localparam int ERR_PID = 0;
   localparam logic [7:0] ERR_MASK = 8'hbf;

   // control field positions
   localparam int CTL_SUSPEND = 5;
   localparam int CTL_RESUME = 2;
   localparam int CTL_PPRST = 1;
   localparam int CTL_ENABLE = 0;

   // status field positions
   localparam int STAT_EP_MSB = 7;
   localparam int STAT_EP_LSB = 4;
   localparam int STAT_DIR = 3;
   localparam int STAT_ODD = 2;

   // interrupt status field positions
   localparam int IRQ_TOKDONE = 3;
   localparam int IRQ_ERROR = 1;

   // reset values and sizes
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int STAT_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int NUM_EP = 7;
   localparam int FIRST_DB_EP = 5;

endpackage

// *** status_fifo.sv ***
// Purpose: small byte fifo holding completed transaction status entries
// Assumes: one clock, push and pop in the same cycle allowed
// Notes: head is shown directly from the array, no read latency
`timescale 1ns/100ps
`default_nettype none

module status_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,                  // system clock
   input wire logic resetn,               // async reset, active low
   input wire logic push_valid,           // entry offered
   output logic push_ready,               // room for an entry
   input wire logic [WIDTH-1:0] push_data, // entry to store
   input wire logic pop,                  // drop the head entry
   output logic head_valid,               // head entry present
   output logic [WIDTH-1:0] head_data     // head entry
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] count_q;
   logic do_push;
   logic do_pop;

   // honest flags straight from the occupancy count; full only at DEPTH entries
   assign push_ready = (count_q < (PW+1)'(DEPTH));
   assign head_valid = (count_q != '0);
   assign head_data = mem_q[rd_q];
   assign do_push = push_valid && push_ready;
   assign do_pop = pop && head_valid;

   // storage, written behind the entry on show
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wr_q] <= push_data;
      end
   end

   // pointers and count; simultaneous push and pop keep the count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         case ({do_push, do_pop})
            2'b10: count_q <= count_q + 1'b1;
            2'b01: count_q <= count_q - 1'b1;
            default: count_q <= count_q;
         endcase
      end
   end

   property p_fifo_no_overrun;
      @(posedge clk) disable iff (!resetn)
      !push_ready |-> (count_q == (PW+1)'(DEPTH));
   endproperty
   a_fifo_no_overrun: assert property (p_fifo_no_overrun) else $error("fifo refused while not full");

endmodule
`default_nettype wire

// *** engine_model.sv ***
// Purpose: behavioural serial engine that completes transactions and reports errors
// Assumes: one clock, bench commands are one-cycle pulses
// Notes: status fields change every cycle while no transaction is pending
`timescale 1ns/100ps
`default_nettype none

module engine_model (
   input wire logic clk,             // system clock
   input wire logic resetn,          // async reset, active low
   input wire logic start,           // queue one transaction
   input wire logic [5:0] fields,    // endpoint, direction, bank
   input wire logic [7:0] err_req,   // error pulses to pass on
   input wire logic setup_req,       // setup token to pass on
   input wire logic txn_ready,       // status fifo has room
   input wire logic txn_halt,        // packet traffic stopped
   output logic busy,                // transaction pending
   output logic txn_done,            // transaction completed
   output logic [5:0] txn_fields,    // endpoint, direction, bank
   output logic [7:0] err_event,     // error detections
   output logic setup_token          // setup token seen
);

////////////////////////////////////////////////////////////////////////////////
// halt blocks completion
assign txn_done = busy & ~txn_halt;

// one entry per descriptor
// a full fifo makes the engine wait, it never drops a completion
always_ff @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      busy <= 1'h0;
      txn_fields <= 6'h00;
   end else if (start) begin
      busy <= 1'h1;
      txn_fields <= fields;
   end else if (txn_done & txn_ready) begin
      busy <= 1'h0;
      txn_fields <= ~txn_fields;
   end else if (!busy) begin
      txn_fields <= ~txn_fields; // junk while idle
   end
end

// error and setup events one cycle after the request
always_ff @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      err_event <= 8'h00;
      setup_token <= 1'h0;
   end else begin
      err_event <= err_req;
      setup_token <= setup_req;
   end
end

endmodule
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench for the usb status and control slice
// Assumes: zero wait state apb slave, engine model on the event side
// Notes: random fields from a fixed seed, corner cases mixed in
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import usb_status_pkg::*;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic start, setup_req, busy, txn_done, txn_ready, setup_token, error_summary, token_done_flag;
   logic txn_halt, resume_drive, engine_reset, module_enable;
   logic [5:0] fields, txn_fields;
   logic [7:0] err_req, err_event, en;
   logic [6:0] pingpong_clear;
   logic [5:0] q[$];
   integer seed = 16076;
   integer fail_count = 0;
   integer checks = 0;

   usb_device_status_control dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .err_event(err_event), .txn_done(txn_done), .txn_endpoint(txn_fields[5:2]),
      .txn_dir_in(txn_fields[1]), .txn_odd(txn_fields[0]), .txn_ready(txn_ready),
      .setup_token(setup_token), .error_summary(error_summary), .token_done_flag(token_done_flag),
      .txn_halt(txn_halt), .resume_drive(resume_drive), .pingpong_clear(pingpong_clear),
      .engine_reset(engine_reset), .module_enable(module_enable));

   engine_model engine (.clk(clk), .resetn(resetn), .start(start), .fields(fields),
      .err_req(err_req), .setup_req(setup_req), .txn_ready(txn_ready), .txn_halt(txn_halt),
      .busy(busy), .txn_done(txn_done), .txn_fields(txn_fields), .err_event(err_event),
      .setup_token(setup_token));

////////////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      fail_count = fail_count + 1;
      finish_test();
   end

   task automatic finish_test();
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks = checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // status byte as the register shows it
   function automatic logic [31:0] stat_exp(input logic [5:0] f);
      return {24'h000000, f, 2'h0};
   endfunction

////////////////////////////////////////////////////////////////////////////////
   // apb master, holds the request until pready is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic pulse_err(input int i);
      @(posedge clk);
      err_req <= 8'h01 << i;
      @(posedge clk);
      err_req <= 8'h00;
   endtask

   // queue one transaction once the engine is free
   task automatic push(input logic [5:0] f);
      @(negedge clk);
      while (busy !== 1'h0) begin
         @(negedge clk);
      end
      @(posedge clk);
      start <= 1'h1;
      fields <= f;
      q.push_back(f);
      @(posedge clk);
      start <= 1'h0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

////////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, start, setup_req} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      err_req = 8'h00;
      fields = 6'h00;
      resetn = 1'h0;
      repeat (5) @(posedge clk);
      resetn <= 1'h1;
      settle(1);
      chk("flag", 0, token_done_flag);
      chk("ready", 1, txn_ready);
      for (int a = 0; a < 3; a++) begin
         xfer(0, 12'(a * 4), 0);
         chk("reset reg", 0, r);
      end
      xfer(0, 12'h020, 0);
      chk("unmapped", 32'h1, {r[30:0], last_err});
      for (int i = 0; i < 8; i++) begin
         if (i == 6) continue;
         en = 8'($random(seed));
         en[i] = i[0];
         xfer(1, ERR_EN_OFS, {24'h0, en});
         xfer(0, ERR_EN_OFS, 0);
         chk("enable", {24'h0, en & ERR_MASK}, r);
         pulse_err(i);
         settle(2);
         chk("summary", en[i], error_summary);
         xfer(1, ERR_FLAG_OFS, 0);
         settle(1);
         chk("summary kept", en[i], error_summary);
         xfer(0, ERR_FLAG_OFS, 0);
         chk("flag kept", 32'h1 << i, r);
         xfer(0, IRQ_OFS, 0);
         chk("irq err", 32'(en[i]) << 1, r);
         xfer(1, ERR_FLAG_OFS, 32'h1 << i);
         xfer(0, ERR_FLAG_OFS, 0);
         chk("flag cleared", 0, r);
      end
      // five completions into a four-entry fifo, corner entry first
      push(6'h1b);
      for (int k = 0; k < 4; k++) begin
         push({4'($unsigned($random(seed)) % 7), 2'($random(seed))});
      end
      settle(3);
      chk("full", 0, txn_ready);
      for (int k = 0; k < 5; k++) begin
         chk("flag set", 1, token_done_flag);
         xfer(0, STATUS_OFS, 0);
         chk("status", stat_exp(q[k]), r);
         xfer(1, IRQ_OFS, 32'h08);
         settle(2);
      end
      chk("empty flag", 0, token_done_flag);
      xfer(0, STATUS_OFS, 0);
      chk("status empty", 0, r);
      q.delete();
      @(posedge clk);
      setup_req <= 1'h1;
      @(posedge clk);
      setup_req <= 1'h0;
      push(6'h04);
      settle(5);
      chk("halt", 1, txn_halt);
      chk("halted flag", 0, token_done_flag);
      xfer(0, CTL_OFS, 0);
      chk("ctl suspend", 32'h20, r);
      xfer(1, CTL_OFS, 0);
      settle(3);
      chk("resumed", {1'h0, 1'h1}, {txn_halt, token_done_flag});
      xfer(0, STATUS_OFS, 0);
      chk("held status", stat_exp(6'h04), r);
      xfer(1, IRQ_OFS, 32'h08);
      xfer(1, CTL_OFS, 32'h04);
      settle(1);
      chk("resume on", 1, resume_drive);
      xfer(1, CTL_OFS, 32'h02);
      settle(1);
      chk("resume off", 0, resume_drive);
      chk("pingpong", 32'h60, pingpong_clear);
      xfer(1, CTL_OFS, 32'h00);
      settle(1);
      chk("pingpong off", 0, pingpong_clear);
      xfer(1, CTL_OFS, 32'h01);
      #1;
      chk("enable pulse", {3'h7, 7'h60}, {engine_reset, module_enable, 1'h1, pingpong_clear});
      @(posedge clk);
      #1;
      chk("enable after", {3'h2, 7'h00}, {engine_reset, module_enable, 1'h0, pingpong_clear});
      xfer(1, CTL_OFS, 32'h00);
      settle(1);
      chk("disabled", 0, module_enable);
      finish_test();
   end

endmodule
`default_nettype wire
